// [dma_request.sv]
`timescale 1ns/1ps
module dma_request (
    input wire logic sys_clk,
    input wire logic rst,
    input wire uart_shadow_pkg::dma_mode_t mode,
    input wire logic single_cond,
    input wire logic block_start,
    input wire logic block_stop,
    output logic req_n
);
    import uart_shadow_pkg::*;

    req_state_t state_r;
    req_state_t state_nxt;
    logic req_n_r;
    logic req_n_nxt;

    // block mode holds the request from start until stop, so a burst is not split
    assign state_nxt = (state_r == REQ_IDLE) ? (block_start ? REQ_ACTIVE : REQ_IDLE)
                     : (block_stop ? REQ_IDLE : REQ_ACTIVE);
    assign req_n_nxt = (mode == DMA_MODE_BLOCK) ? (state_nxt != REQ_ACTIVE) : ~single_cond;

    // request state and active-low output
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r <= REQ_IDLE;
            req_n_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            req_n_r <= req_n_nxt;
        end
    end

    assign req_n = req_n_r;

    block_hold_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (mode == DMA_MODE_BLOCK && state_r == REQ_ACTIVE && !block_stop) |=> !req_n_r
    ) else $error("block request dropped before stop");

endmodule

// [fifo_partner.sv]
`timescale 1ns/1ps
// far side: fifo fill counters plus a dma engine that moves one word a cycle
module fifo_partner #(
    parameter int DEPTH = 16,
    parameter int LEVEL_W = 5
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire uart_shadow_pkg::fifo_ctrl_t fifo_ctrl,
    input wire uart_shadow_pkg::dma_req_t dma_req,
    input wire logic load,
    input wire logic [LEVEL_W-1:0] rx_load,
    input wire logic [LEVEL_W-1:0] tx_load,
    input wire logic dma_on,
    output logic [LEVEL_W-1:0] rx_level,
    output logic [LEVEL_W-1:0] tx_level
);
    import uart_shadow_pkg::*;
    // controller resets empty the fifos; the bench load wins so levels stay predictable
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_level <= '0;
            tx_level <= '0;
        end else if (load) begin
            rx_level <= rx_load;
            tx_level <= tx_load;
        end else begin
            if (fifo_ctrl.rx_reset) rx_level <= '0;
            else if (dma_on && !dma_req.rx_n && rx_level != 0) rx_level <= rx_level - 1'b1;
            if (fifo_ctrl.tx_reset) tx_level <= '0;
            else if (dma_on && !dma_req.tx_n && tx_level < LEVEL_W'(DEPTH))
                tx_level <= tx_level + 1'b1;
        end
    end
endmodule

// [rx_trigger_level.sv]
`timescale 1ns/1ps
module rx_trigger_level #(
    parameter int DEPTH = 16,
    parameter int LEVEL_W = 5
) (
    input wire uart_shadow_pkg::rx_trig_t code,
    output logic [LEVEL_W-1:0] threshold
);
    import uart_shadow_pkg::*;

    // fill at which the received-data-available condition rises
    function automatic logic [LEVEL_W-1:0] trig_fill(input rx_trig_t c);
        case (c)
            TRIG_ONE: trig_fill = LEVEL_W'(1);
            TRIG_QUARTER: trig_fill = LEVEL_W'(DEPTH / 4);
            TRIG_HALF: trig_fill = LEVEL_W'(DEPTH / 2);
            TRIG_NEAR_FULL: trig_fill = LEVEL_W'(DEPTH - 2);
            default: trig_fill = LEVEL_W'(1);
        endcase
    endfunction

    assign threshold = trig_fill(code);

endmodule

// [testbench.sv]
`timescale 1ns/1ps
module testbench;
    import uart_shadow_pkg::*;
    localparam int DEPTH = 16;
    localparam int LW = 5;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    bus_req_t bus = '0;
    logic [DATA_W-1:0] rdata;
    logic [LW-1:0] rx_level;
    logic [LW-1:0] tx_level;
    logic [LW-1:0] rx_load = '0;
    logic [LW-1:0] tx_load = '0;
    logic load = 1'b0;
    logic dma_on = 1'b0;
    fifo_ctrl_t fifo_ctrl;
    dma_req_t dma_req;
    logic rx_avail;
    logic irq;
    int failures = 0;
    int checked = 0;
    logic [31:0] seed = 32'h0000_0034;
    logic [15:0] d;
    logic [15:0] exp_al [3] = '{16'h0, 16'h0, 16'h0};
    logic [31:0] al_addr [3] = '{OFS_DMA_MODE_ALIAS, OFS_FIFO_EN_ALIAS, OFS_RX_TRIG_ALIAS};
    logic [15:0] al_mask [3] = '{16'h0001, 16'h0001, 16'h0003};

    uart_fifo_dma_shadow_controls #(.DEPTH(DEPTH), .LEVEL_W(LW)) dut (
        .sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata(rdata), .rx_level(rx_level),
        .tx_level(tx_level), .fifo_ctrl(fifo_ctrl), .dma_req(dma_req), .rx_avail(rx_avail),
        .irq(irq));
    fifo_partner #(.DEPTH(DEPTH), .LEVEL_W(LW)) far_side (
        .sys_clk(sys_clk), .rst(rst), .fifo_ctrl(fifo_ctrl), .dma_req(dma_req), .load(load),
        .rx_load(rx_load), .tx_load(tx_load), .dma_on(dma_on), .rx_level(rx_level),
        .tx_level(tx_level));

    // free running clock
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    // repeatable random source
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // fill at which data counts as available
    function automatic int thr(input logic [1:0] c);
        case (c)
            2'b00: return 1;
            2'b01: return DEPTH / 4;
            2'b10: return DEPTH / 2;
            default: return DEPTH - 2;
        endcase
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one-cycle write; strobe drops at the edge that takes it
    task automatic wr(input logic [31:0] a, input logic [15:0] v);
        @(posedge sys_clk);
        bus.addr <= a;
        bus.wdata <= v;
        bus.wr <= 1'b1;
        @(posedge sys_clk);
        bus.wr <= 1'b0;
        #1;
    endtask

    // read data only stands in the cycle after the strobe
    task automatic rd(input logic [31:0] a, output logic [15:0] v);
        @(posedge sys_clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        #1 v = rdata;
    endtask

    // write then read with no idle cycle between the strobes
    task automatic wr_rd(input logic [31:0] wa, input logic [15:0] v, input logic [31:0] ra,
                         output logic [15:0] q);
        @(posedge sys_clk);
        bus.addr <= wa;
        bus.wdata <= v;
        bus.wr <= 1'b1;
        @(posedge sys_clk);
        bus.addr <= ra;
        bus.wr <= 1'b0;
        bus.rd <= 1'b1;
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        #1 q = rdata;
    endtask

    // partner loads at one edge, the block reacts at the next
    task automatic lvl(input int r, input int t);
        @(posedge sys_clk);
        load <= 1'b1;
        rx_load <= LW'(r);
        tx_load <= LW'(t);
        @(posedge sys_clk);
        load <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic chk_alias();
        for (int i = 0; i < 3; i++) begin
            rd(al_addr[i], d);
            chk(d, exp_al[i], "alias readback");
        end
    endtask

    task automatic results();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        results();
    end

    initial begin
        int k;
        int lv;
        logic [31:0] r;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        chk_alias();
        rd(32'h5000_11a0, d);
        chk(d, 16'h0, "unmapped read");
        rd(OFS_FIFO_CONTROL_WORD, d);
        chk(d, 16'h0, "control word reads zero");
        @(posedge sys_clk);
        #1 chk(rdata, 16'h0, "rdata idle");
        $display("test reset done");
        // random alias writes must touch one field only
        for (int i = 0; i < 24; i++) begin
            r = xs();
            k = int'(r[17:16]) % 3;
            wr(al_addr[k], r[15:0]);
            exp_al[k] = r[15:0] & al_mask[k];
            chk(fifo_ctrl.enable, exp_al[1][0], "enable");
            chk_alias();
        end
        wr(32'h5000_11a0, 16'hffff);
        chk_alias();
        wr(OFS_FIFO_CONTROL_WORD, 16'h00c9);
        exp_al = '{16'h1, 16'h1, 16'h3};
        chk_alias();
        wr_rd(OFS_FIFO_CONTROL_WORD, 16'h0089, OFS_RX_TRIG_ALIAS, d);
        chk(d, 16'h2, "trigger from control word");
        wr(OFS_FIFO_CONTROL_WORD, 16'h0006);
        chk({fifo_ctrl.rx_reset, fifo_ctrl.tx_reset}, 16'h3, "control reset");
        exp_al = '{16'h0, 16'h0, 16'h0};
        chk_alias();
        $display("test alias done");
        // disable after enable resets both fifos and flags an event
        wr(OFS_IRQ_MASK, 16'h0002);
        wr(OFS_IRQ_STATUS, 16'h0007);
        wr(OFS_FIFO_EN_ALIAS, 16'h0001);
        chk(fifo_ctrl, 16'h4, "enable set");
        wr(OFS_FIFO_EN_ALIAS, 16'h0000);
        chk(fifo_ctrl, 16'h3, "disable resets");
        chk(irq, 16'h1, "irq on disable");
        @(posedge sys_clk);
        #1 chk(fifo_ctrl, 16'h0, "reset pulse ends");
        wr(OFS_FIFO_EN_ALIAS, 16'h0000);
        chk(fifo_ctrl, 16'h0, "no reset when already off");
        wr(OFS_IRQ_STATUS, 16'h0002);
        chk(irq, 16'h0, "irq cleared");
        wr(OFS_IRQ_MASK, 16'h0000);
        wr(OFS_FIFO_EN_ALIAS, 16'h0001);
        wr(OFS_FIFO_EN_ALIAS, 16'h0000);
        chk(irq, 16'h0, "masked irq");
        rd(OFS_IRQ_STATUS, d);
        chk(d[1], 16'h1, "sticky status");
        $display("test enable done");
        // every trigger code at its boundary, then random fills
        wr(OFS_FIFO_EN_ALIAS, 16'h0001);
        for (int c = 0; c < 4; c++) begin
            wr(OFS_RX_TRIG_ALIAS, 16'(c));
            for (int j = 0; j < 2; j++) begin
                lvl(thr(2'(c)) - 1 + j, 1);
                chk(rx_avail, 16'(j), "trigger boundary");
            end
        end
        for (int i = 0; i < 16; i++) begin
            r = xs();
            lv = int'(r[15:8]) % 17;
            wr(OFS_RX_TRIG_ALIAS, {14'h0, r[1:0]});
            lvl(lv, 1);
            chk(rx_avail, 16'(lv >= thr(r[1:0])), "random trigger");
        end
        $display("test trigger done");
        // mode 0 follows levels, mode 1 holds requests between marks
        wr(OFS_DMA_MODE_ALIAS, 16'h0000);
        lvl(3, 5);
        chk({dma_req.rx_n, dma_req.tx_n}, 16'h1, "mode0 data");
        rd(OFS_FIFO_STATUS, d);
        chk(d, 16'h0503, "fifo status");
        wr(OFS_IRQ_STATUS, 16'h0007);
        lvl(0, 0);
        chk({dma_req.rx_n, dma_req.tx_n}, 16'h2, "mode0 empty");
        rd(OFS_IRQ_STATUS, d);
        chk(d[2], 16'h1, "transmit empty event");
        wr(OFS_DMA_MODE_ALIAS, 16'h0001);
        wr(OFS_RX_TRIG_ALIAS, 16'h0002);
        lvl(7, 0);
        chk({dma_req.rx_n, dma_req.tx_n}, 16'h2, "mode1 below");
        lvl(8, 5);
        chk({dma_req.rx_n, dma_req.tx_n}, 16'h0, "mode1 trigger");
        lvl(3, 16);
        chk({dma_req.rx_n, dma_req.tx_n}, 16'h1, "mode1 hold");
        lvl(0, 5);
        chk({dma_req.rx_n, dma_req.tx_n}, 16'h3, "mode1 release");
        lvl(12, 16);
        dma_on <= 1'b1;
        for (int i = 0; i < 40 && dma_req.rx_n !== 1'b1; i++) @(posedge sys_clk);
        #1 chk({dma_req.rx_n, 10'h0, rx_level}, 16'h8000, "dma drain");
        dma_on <= 1'b0;
        $display("test dma done");
        results();
    end
endmodule

// [uart_fifo_dma_shadow_controls.sv]
`timescale 1ns/1ps
// Summary of operation
// - dma mode alias writes only dma bit
// - dma mode selects request signalling scheme
// - fifo enable alias writes only enable
// - one enable switches both fifos together
// - enable cleared after set resets fifos
// - trigger alias writes only receive trigger
// - trigger code sets receive available fill
// - block mode receive request follows trigger
module uart_fifo_dma_shadow_controls #(
    parameter int DEPTH = 16,
    parameter int LEVEL_W = 5
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire uart_shadow_pkg::bus_req_t bus,
    output logic [uart_shadow_pkg::DATA_W-1:0] rdata,
    input wire logic [LEVEL_W-1:0] rx_level,
    input wire logic [LEVEL_W-1:0] tx_level,
    output uart_shadow_pkg::fifo_ctrl_t fifo_ctrl,
    output uart_shadow_pkg::dma_req_t dma_req,
    output logic rx_avail,
    output logic irq
);
    import uart_shadow_pkg::*;

    // refuse shapes the trigger table and status layout cannot serve
    generate
        if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
            $error("DEPTH must be a power of two, at least 4");
        end
        if (LEVEL_W != $clog2(DEPTH + 1) || LEVEL_W > FST_TX_LEVEL_LSB) begin : g_bad_lw
            $error("LEVEL_W must equal clog2(DEPTH+1) and fit 8 bits");
        end
    endgenerate

    // address match, shared by write and read decode
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    // state kept for software
    dma_mode_t dma_mode_r;
    dma_mode_t dma_mode_nxt;
    logic fifo_en_r;
    logic fifo_en_nxt;
    rx_trig_t rx_trig_r;
    rx_trig_t rx_trig_nxt;
    logic [IRQ_W-1:0] irq_status_r;
    logic [IRQ_W-1:0] irq_status_nxt;
    logic [IRQ_W-1:0] irq_mask_r;
    logic [IRQ_W-1:0] irq_mask_nxt;

    // state driven toward the fifos and the pins
    logic rx_rst_r;
    logic rx_rst_nxt;
    logic tx_rst_r;
    logic tx_rst_nxt;
    logic rx_avail_r;
    logic rx_avail_nxt;
    logic tx_empty_r;
    logic tx_empty_nxt;
    logic irq_r;
    logic irq_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;

    // address decode
    logic [DATA_W-1:0] wd;
    logic hit_dma;
    logic hit_fen;
    logic hit_trig;
    logic hit_fcw;
    logic hit_stat;
    logic hit_mask;
    logic hit_fst;
    logic hit_any;

    assign wd = bus.wdata;
    assign hit_dma = hit(bus.addr, OFS_DMA_MODE_ALIAS);
    assign hit_fen = hit(bus.addr, OFS_FIFO_EN_ALIAS);
    assign hit_trig = hit(bus.addr, OFS_RX_TRIG_ALIAS);
    assign hit_fcw = hit(bus.addr, OFS_FIFO_CONTROL_WORD);
    assign hit_stat = hit(bus.addr, OFS_IRQ_STATUS);
    assign hit_mask = hit(bus.addr, OFS_IRQ_MASK);
    assign hit_fst = hit(bus.addr, OFS_FIFO_STATUS);
    assign hit_any = hit_dma | hit_fen | hit_trig | hit_fcw | hit_stat | hit_mask | hit_fst;

    // write strobes per register
    logic wr_dma;
    logic wr_fen;
    logic wr_trig;
    logic wr_fcw;
    logic wr_stat;
    logic wr_mask;

    assign wr_dma = bus.wr & hit_dma;
    assign wr_fen = bus.wr & hit_fen;
    assign wr_trig = bus.wr & hit_trig;
    assign wr_fcw = bus.wr & hit_fcw;
    assign wr_stat = bus.wr & hit_stat;
    assign wr_mask = bus.wr & hit_mask;

    // aliases and the control word land in one copy, so no stale mirror exists
    assign dma_mode_nxt = wr_dma ? dma_mode_t'(wd[0]) :
                          wr_fcw ? dma_mode_t'(wd[FCW_DMA_BIT]) : dma_mode_r;
    assign fifo_en_nxt = wr_fen ? wd[0] :
                         wr_fcw ? wd[FCW_EN_BIT] : fifo_en_r;
    assign rx_trig_nxt = wr_trig ? rx_trig_t'(wd[1:0]) :
                         wr_fcw ? rx_trig_t'(wd[FCW_RX_TRIG_LSB +: 2]) : rx_trig_r;

    // fifo controller reset on a falling enable, or on request in the control word
    logic fifo_off_edge;

    assign fifo_off_edge = fifo_en_r & ~fifo_en_nxt;
    assign rx_rst_nxt = fifo_off_edge | (wr_fcw & wd[FCW_RX_RST_BIT]);
    assign tx_rst_nxt = fifo_off_edge | (wr_fcw & wd[FCW_TX_RST_BIT]);

    // receive threshold; with fifos off a single held character counts
    logic [LEVEL_W-1:0] rx_thr;
    logic [LEVEL_W-1:0] eff_rx_thr;
    logic [LEVEL_W-1:0] tx_full_lvl;

    rx_trigger_level #(
        .DEPTH(DEPTH),
        .LEVEL_W(LEVEL_W)
    ) u_rx_trig (
        .code(rx_trig_r),
        .threshold(rx_thr)
    );

    assign eff_rx_thr = fifo_en_r ? rx_thr : LEVEL_W'(1);
    assign tx_full_lvl = fifo_en_r ? LEVEL_W'(DEPTH) : LEVEL_W'(1);
    assign rx_avail_nxt = (rx_level >= eff_rx_thr);
    assign tx_empty_nxt = (tx_level == '0);

    // interrupt events; a set in the clearing cycle survives
    logic [IRQ_W-1:0] irq_event;
    logic [IRQ_W-1:0] irq_clear;

    assign irq_event[IRQ_RX_AVAIL] = rx_avail_nxt & ~rx_avail_r;
    assign irq_event[IRQ_FIFO_RESET] = fifo_off_edge;
    assign irq_event[IRQ_TX_EMPTY] = tx_empty_nxt & ~tx_empty_r;
    assign irq_clear = wr_stat ? wd[IRQ_W-1:0] : '0;
    assign irq_status_nxt = (irq_status_r & ~irq_clear) | irq_event;
    assign irq_mask_nxt = wr_mask ? wd[IRQ_W-1:0] : irq_mask_r;
    assign irq_nxt = |(irq_status_nxt & irq_mask_nxt);

    // read mux; the control word itself is write only and reads zero
    logic [DATA_W-1:0] rd_val;
    logic [DATA_W-1:0] fst_val;

    assign fst_val = {{(DATA_W - FST_TX_LEVEL_LSB - LEVEL_W){1'b0}}, tx_level,
                      {(FST_TX_LEVEL_LSB - LEVEL_W){1'b0}}, rx_level};
    assign rd_val = hit_dma ? {{(DATA_W - 1){1'b0}}, dma_mode_r} :
                    hit_fen ? {{(DATA_W - 1){1'b0}}, fifo_en_r} :
                    hit_trig ? {{(DATA_W - 2){1'b0}}, rx_trig_r} :
                    hit_stat ? {{(DATA_W - IRQ_W){1'b0}}, irq_status_r} :
                    hit_mask ? {{(DATA_W - IRQ_W){1'b0}}, irq_mask_r} :
                    hit_fst ? fst_val : '0;
    // data stand only in the cycle after the strobe
    assign rdata_nxt = (bus.rd & hit_any) ? rd_val : '0;

    // software-visible registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dma_mode_r <= dma_mode_t'(RST_DMA_MODE);
            fifo_en_r <= RST_FIFO_EN;
            rx_trig_r <= rx_trig_t'(RST_RX_TRIG);
            irq_status_r <= RST_IRQ;
            irq_mask_r <= RST_IRQ;
        end else begin
            dma_mode_r <= dma_mode_nxt;
            fifo_en_r <= fifo_en_nxt;
            rx_trig_r <= rx_trig_nxt;
            irq_status_r <= irq_status_nxt;
            irq_mask_r <= irq_mask_nxt;
        end
    end

    // registered outputs and edge history
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_rst_r <= 1'b0;
            tx_rst_r <= 1'b0;
            rx_avail_r <= 1'b0;
            tx_empty_r <= 1'b1; // idle fifo is empty, so no false event after reset
            irq_r <= 1'b0;
            rdata_r <= RST_RDATA;
        end else begin
            rx_rst_r <= rx_rst_nxt;
            tx_rst_r <= tx_rst_nxt;
            rx_avail_r <= rx_avail_nxt;
            tx_empty_r <= tx_empty_nxt;
            irq_r <= irq_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // dma request generators; block mode uses trigger and full marks
    logic rx_req_n;
    logic tx_req_n;

    dma_request u_rx_req (
        .sys_clk(sys_clk),
        .rst(rst),
        .mode(dma_mode_r),
        .single_cond(rx_level != '0),
        .block_start(rx_level >= eff_rx_thr),
        .block_stop(rx_level == '0),
        .req_n(rx_req_n)
    );

    dma_request u_tx_req (
        .sys_clk(sys_clk),
        .rst(rst),
        .mode(dma_mode_r),
        .single_cond(tx_level == '0),
        .block_start(tx_level == '0),
        .block_stop(tx_level >= tx_full_lvl),
        .req_n(tx_req_n)
    );

    // one enable drives both fifos
    assign fifo_ctrl = '{enable: fifo_en_r, tx_reset: tx_rst_r, rx_reset: rx_rst_r};
    assign dma_req = '{tx_n: tx_req_n, rx_n: rx_req_n};
    assign rx_avail = rx_avail_r;
    assign irq = irq_r;
    assign rdata = rdata_r;

    dma_alias_wr_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        wr_dma |=> (dma_mode_r == dma_mode_t'($past(wd[0])))
            && (fifo_en_r == $past(fifo_en_r)) && (rx_trig_r == $past(rx_trig_r))
    ) else $error("dma alias write wrong or disturbed other fields");

    single_rx_req_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (dma_mode_r == DMA_MODE_SINGLE && rx_level != '0) |=> !dma_req.rx_n
    ) else $error("single mode receive request missing");

    fen_alias_wr_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        wr_fen |=> (fifo_en_r == $past(wd[0]))
            && (dma_mode_r == $past(dma_mode_r)) && (rx_trig_r == $past(rx_trig_r))
    ) else $error("fifo enable alias write wrong or disturbed other fields");

    fifo_gang_en_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (wr_fen ##1 !wr_fen && !wr_fcw) |=> fifo_ctrl.enable == $past(wd[0], 2)
    ) else $error("fifo enable did not follow write");

    fifo_off_reset_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        $fell(fifo_en_r) |-> (fifo_ctrl.rx_reset && fifo_ctrl.tx_reset)
            ##1 (!fifo_ctrl.rx_reset || $past(wr_fcw))
    ) else $error("fifo reset not pulsed on disable");

    trig_alias_wr_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        wr_trig |=> (rx_trig_r == rx_trig_t'($past(wd[1:0])))
            && (fifo_en_r == $past(fifo_en_r)) && (dma_mode_r == $past(dma_mode_r))
    ) else $error("trigger alias write wrong or disturbed other fields");

    near_full_thr_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (fifo_en_r && rx_trig_r == TRIG_NEAR_FULL && rx_level == LEVEL_W'(DEPTH - 3))
            |=> !rx_avail
    ) else $error("receive available raised below near-full mark");

    block_rx_wait_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (dma_mode_r == DMA_MODE_BLOCK && dma_req.rx_n && rx_level < eff_rx_thr)
            |=> dma_req.rx_n
    ) else $error("block mode receive request before trigger");

    shared_store_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        wr_fcw ##1 (bus.rd && hit_trig)
            |=> rdata == {{(DATA_W - 2){1'b0}}, $past(wd[FCW_RX_TRIG_LSB +: 2], 2)}
    ) else $error("trigger alias does not read control word value");

    irq_sticky_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (irq_status_r[IRQ_FIFO_RESET] && !wr_stat) |=> irq_status_r[IRQ_FIFO_RESET]
    ) else $error("interrupt status bit lost without clear");

    irq_level_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        irq == |(irq_status_r & irq_mask_r)
    ) else $error("interrupt output disagrees with status and mask");

    read_pulse_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        !bus.rd |=> rdata == '0
    ) else $error("read data present without read strobe");

    fcw_write_all_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        wr_fcw |=> (fifo_en_r == $past(wd[FCW_EN_BIT]))
            && (dma_mode_r == dma_mode_t'($past(wd[FCW_DMA_BIT])))
            && (rx_trig_r == rx_trig_t'($past(wd[FCW_RX_TRIG_LSB +: 2])))
    ) else $error("control word write did not reach all fields");

    fifo_no_reset_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (!fifo_en_r && !wr_fcw) |=> (!fifo_ctrl.rx_reset && !fifo_ctrl.tx_reset)
    ) else $error("fifo reset without a falling enable");

    resets_paired_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        !$past(wr_fcw) |-> (fifo_ctrl.rx_reset == fifo_ctrl.tx_reset)
    ) else $error("fifo resets split without a control word write");

    one_char_thr_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (fifo_en_r && rx_trig_r == TRIG_ONE && rx_level != '0) |=> rx_avail
    ) else $error("receive available missing at one character");

    quarter_thr_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (fifo_en_r && rx_trig_r == TRIG_QUARTER && rx_level == LEVEL_W'(DEPTH / 4 - 1))
            |=> !rx_avail
    ) else $error("receive available raised below quarter mark");

    half_thr_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (fifo_en_r && rx_trig_r == TRIG_HALF && rx_level == LEVEL_W'(DEPTH / 2))
            |=> rx_avail
    ) else $error("receive available missing at half mark");

    block_rx_release_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (dma_mode_r == DMA_MODE_BLOCK && rx_level == '0) |=> dma_req.rx_n
    ) else $error("block mode receive request held with empty fifo");

    single_tx_req_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (dma_mode_r == DMA_MODE_SINGLE && tx_level != '0) |=> dma_req.tx_n
    ) else $error("single mode transmit request with data waiting");

    block_tx_hold_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        (dma_mode_r == DMA_MODE_BLOCK && fifo_en_r && !dma_req.tx_n
            && tx_level < LEVEL_W'(DEPTH)) |=> !dma_req.tx_n
    ) else $error("block mode transmit request dropped before full");

endmodule

// [uart_shadow_pkg.sv]
package uart_shadow_pkg;

    // bus geometry
    localparam int ADDR_W = 32;
    localparam int DATA_W = 16;

    // register byte addresses
    localparam logic [31:0] OFS_DMA_MODE_ALIAS = 32'h5000_1194;
    localparam logic [31:0] OFS_FIFO_EN_ALIAS = 32'h5000_1198;
    localparam logic [31:0] OFS_RX_TRIG_ALIAS = 32'h5000_119c;
    localparam logic [31:0] OFS_FIFO_CONTROL_WORD = 32'h5000_1108;
    localparam logic [31:0] OFS_IRQ_STATUS = 32'h5000_11e0;
    localparam logic [31:0] OFS_IRQ_MASK = 32'h5000_11e4;
    localparam logic [31:0] OFS_FIFO_STATUS = 32'h5000_11e8;

    // fifo control word field positions
    localparam int FCW_EN_BIT = 0;
    localparam int FCW_RX_RST_BIT = 1;
    localparam int FCW_TX_RST_BIT = 2;
    localparam int FCW_DMA_BIT = 3;
    localparam int FCW_RX_TRIG_LSB = 6;

    // fifo status register field positions
    localparam int FST_TX_LEVEL_LSB = 8;

    // interrupt status bits
    localparam int IRQ_W = 3;
    localparam int IRQ_RX_AVAIL = 0;
    localparam int IRQ_FIFO_RESET = 1;
    localparam int IRQ_TX_EMPTY = 2;

    // values after reset
    localparam logic RST_DMA_MODE = 1'b0;
    localparam logic RST_FIFO_EN = 1'b0;
    localparam logic [1:0] RST_RX_TRIG = 2'h0;
    localparam logic [IRQ_W-1:0] RST_IRQ = 3'h0;
    localparam logic [DATA_W-1:0] RST_RDATA = 16'h0;

    typedef enum logic [1:0] {
        TRIG_ONE = 2'b00,
        TRIG_QUARTER = 2'b01,
        TRIG_HALF = 2'b10,
        TRIG_NEAR_FULL = 2'b11
    } rx_trig_t;

    typedef enum logic {
        DMA_MODE_SINGLE = 1'b0,
        DMA_MODE_BLOCK = 1'b1
    } dma_mode_t;

    typedef enum logic {
        REQ_IDLE = 1'b0,
        REQ_ACTIVE = 1'b1
    } req_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic enable;
        logic tx_reset;
        logic rx_reset;
    } fifo_ctrl_t;

    typedef struct packed {
        logic tx_n;
        logic rx_n;
    } dma_req_t;

endpackage
